// ===== hw/clock_sync_pkg.sv
// constants and types shared by the sample clock control block
package clock_sync_pkg;

  // serial configuration frame: 4 address bits then 16 data bits, msb first
  localparam int          ADDR_W       = 4;
  localparam int          DATA_W       = 16;
  localparam logic [4:0]  FRAME_LAST   = 5'h13;

  // register offsets
  localparam logic [3:0]  ADDR_EXT_CONFIG = 4'h9;
  localparam logic [3:0]  ADDR_GAIN       = 4'hb;
  localparam logic [3:0]  ADDR_FINE       = 4'he;
  localparam logic [3:0]  ADDR_COARSE     = 4'hf;

  // values after reset
  localparam logic [15:0] RST_EXT_CONFIG  = 16'h03ff;
  localparam logic [15:0] RST_GAIN        = 16'h807f;
  localparam logic [15:0] RST_FINE        = 16'h00ff;
  localparam logic [15:0] RST_COARSE      = 16'h007f;

  // field positions
  localparam int          GAIN_MSB        = 15;
  localparam int          GAIN_LSB        = 7;
  localparam int          FINE_MSB        = 15;
  localparam int          FINE_LSB        = 8;
  localparam int          INVERT_BIT      = 15;
  localparam int          COARSE_MSB      = 14;
  localparam int          COARSE_LSB      = 10;
  localparam int          INTER_MSB       = 9;
  localparam int          INTER_LSB       = 7;
  localparam int          PATTERN_BIT     = 15;
  localparam int          KEEP_CLOCK_BIT  = 14;

  // analog scaling figures
  localparam int          RANGE_MIN_MV    = 560;
  localparam int          RANGE_SPAN_MV   = 280;
  localparam int          GAIN_FULL_CODE  = 511;
  localparam int          INTER_STEP_PS   = 11;
  localparam int          COARSE_STEP_PS  = 65;
  localparam int          MAX_DELAY_PS    = 2100;

  // restart delay after output clock reset release, in input clock cycles
  localparam logic [2:0]  RESTART_DEMUX0  = 3'h4;
  localparam logic [2:0]  RESTART_OTHER   = 3'h3;

  // clock-to-output delay as a time, and as system clock cycles (rounded up)
  localparam int          CLK_MHZ         = 100;
  localparam int          TOD_NS          = 4;
  localparam int          TOD_RAW         = (TOD_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0]  TOD_CYC         = 4'(TOD_RAW < 1 ? 1 : TOD_RAW);

  // test words; the complement phase flips them
  localparam logic [7:0]  PAT_QD          = 8'h01;
  localparam logic [7:0]  PAT_ID          = 8'h02;
  localparam logic [7:0]  PAT_Q_DEMUX     = 8'h03;
  localparam logic [7:0]  PAT_I_DEMUX     = 8'h04;
  localparam logic [7:0]  PAT_Q_SINGLE    = 8'h01;
  localparam logic [7:0]  PAT_I_SINGLE    = 8'h02;
  localparam logic [3:0]  PAT_LEN_DEMUX   = 4'h5;
  localparam logic [3:0]  PAT_LEN_SINGLE  = 4'ha;
  // bit n is the complement flag of step n
  localparam logic [9:0]  PAT_FLIP_DEMUX  = 10'h00a;
  localparam logic [9:0]  PAT_FLIP_SINGLE = 10'h132;

  localparam int          WORD_W          = 33;
  localparam int          SYNC_W          = 10;

  typedef enum logic [2:0] {
    OUTPUT_DATA_CLOCK_RUN   = 3'b000,
    OUTPUT_DATA_CLOCK_HELD  = 3'b001,
    OUTPUT_DATA_CLOCK_FALL  = 3'b010,
    OUTPUT_DATA_CLOCK_COUNT = 3'b011,
    OUTPUT_DATA_CLOCK_TOD   = 3'b100
  } output_data_clock_state_t;

endpackage

// ===== hw/word_buffer.sv
// small first-in first-out buffer between data selection and the output ports
`timescale 1ns/1ns
`default_nettype none
module word_buffer #(
  parameter int WIDTH = 33,
  parameter int DEPTH = 2
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CNT_W = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [CNT_W-1:0] count;
  logic             push;
  logic             pop;

  function automatic logic [PTR_W-1:0] bump(input logic [PTR_W-1:0] p);
    bump = (p == PTR_W'(DEPTH - 1)) ? '0 : p + PTR_W'(1);
  endfunction

  assign in_ready  = (count != CNT_W'(DEPTH));
  assign out_valid = (count != '0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      if (push) begin
        wr_ptr <= bump(wr_ptr);
      end
      if (pop) begin
        rd_ptr <= bump(rd_ptr);
      end
      if (push && !pop) begin
        count <= count + CNT_W'(1);
      end else if (pop && !push) begin
        count <= count - CNT_W'(1);
      end
    end
  end
endmodule // word_buffer
`default_nettype wire

// ===== hw/sample_clock_sync.sv
// sample clock phase registers, output data clock reset/restart and test pattern
// Functional notes
// R1 - 9-bit upper gain field scales range 560, 700, 840 mV monotonically.
// R2 - host keeps gain code between 0110 0000 0b and 1110 0000 0b.
// R3 - gain change applies at once, no new calibration needed.
// R4 - host writes every unused low register bit as one.
// R5 - 8-bit fine phase field, 0 to about 50 ps, resets to zero.
// R6 - top bit of coarse register inverts sample clock, resets to zero.
// R7 - 3-bit intermediate field, about 11 ps per step, zero at reset.
// R8 - combined coarse and intermediate delay tops out near 2.1 ns.
// R9 - 5-bit coarse field in bits 14:10 adds fixed step, resets zero.
// R10 - output clock invalid while a register word is shifting in.
// R11 - host writes only registers whose contents change.
// R12 - output clock reset accepted any time; clock held at mode level.
// R13 - reset assertion may truncate the clock, leaving one narrow pulse.
// R14 - reset release taken only on next input clock falling edge.
// R15 - restart after 4 cycles in 1:2 zero-degree, else 3, plus delay.
// R16 - host never asserts output clock reset during calibration.
// R17 - output clock stops during calibration unless kept running.
// R18 - pattern mode replaces converted data on all ports and range flag.
// R19 - each port has its own 8-bit word alternating with complement; without demux, q/qd and i/id share words flipped on steps 1,4,5,8 of 10.
// R20 - top bit of extended configuration enables pattern, resets zero.
// R21 - pattern held in reset starts in step on reset release.
// R22 - pattern started without reset may offset channels by one word.
`timescale 1ns/1ns
`default_nettype none
module sample_clock_sync (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        in_clk,
  input  wire logic        output_clock_reset,
  input  wire logic        calibration_running,
  input  wire logic        demux_1to2,
  input  wire logic        demux_zero_phase,
  input  wire logic        sdr_mode,
  input  wire logic        output_edge,
  input  wire logic        scs_n,
  input  wire logic        sclk,
  input  wire logic        sdata,
  input  wire logic [7:0]  conv_i,
  input  wire logic [7:0]  conv_q,
  input  wire logic [7:0]  conv_id,
  input  wire logic [7:0]  conv_qd,
  input  wire logic        conv_or,
  input  wire logic        conv_valid,
  output logic             conv_ready,
  output logic [7:0]       out_i,
  output logic [7:0]       out_q,
  output logic [7:0]       out_id,
  output logic [7:0]       out_qd,
  output logic             out_or,
  output logic             out_valid,
  input  wire logic        out_ready,
  output logic             output_data_clock,
  output logic             data_clock_valid,
  output logic [8:0]       gain_code,
  output logic [9:0]       range_mv,
  output logic [7:0]       fine_phase,
  output logic [4:0]       coarse_phase,
  output logic [2:0]       intermediate_phase_field,
  output logic             sample_clock_invert,
  output logic [11:0]      sample_delay_ps,
  output logic             test_pattern_enable,
  output logic             keep_clock_running
);
  // every control pin is asynchronous to clk, the mode straps included
  logic [clock_sync_pkg::SYNC_W-1:0] sync1;
  logic [clock_sync_pkg::SYNC_W-1:0] sync2;
  logic [clock_sync_pkg::SYNC_W-1:0] prev;
  logic                              ic_rise;
  logic                              ic_fall;
  logic                              sck_rise;
  logic                              orst_s;
  logic                              cal_s;
  logic                              scs_n_s;
  logic [4:0]                        bit_count;
  logic [19:0]                       shift;
  logic                              word_done;
  logic                              write_strobe;
  logic [3:0]                        write_addr;
  logic [15:0]                       write_data;
  logic [15:0]                       reg_ext;
  logic [15:0]                       reg_gain;
  logic [15:0]                       reg_fine;
  logic [15:0]                       reg_coarse;
  clock_sync_pkg::output_data_clock_state_t       state;
  logic [2:0]                        restart_count;
  logic [3:0]                        tod_count;
  logic                              hold_level;
  logic                              div_phase;
  logic                              clock_stopped;
  logic                              toggle;
  logic                              word_evt;
  logic [3:0]                        i_phase;
  logic [3:0]                        q_phase;
  logic                              q_lag;
  logic                              pattern_prev;
  logic [3:0]                        pat_len;
  logic                              i_flip;
  logic                              q_flip;
  logic [clock_sync_pkg::WORD_W-1:0] next_word;
  logic                              buf_in_valid;
  logic                              buf_in_ready;
  logic [clock_sync_pkg::WORD_W-1:0] buf_out_data;
  function automatic logic pattern_flip(input logic [3:0] phase, input logic dmx);
    logic [9:0] table_bits;
    table_bits   = dmx ? clock_sync_pkg::PAT_FLIP_DEMUX : clock_sync_pkg::PAT_FLIP_SINGLE;
    pattern_flip = table_bits[phase];
  endfunction
  function automatic logic [3:0] phase_step(input logic [3:0] phase, input logic [3:0] len);
    phase_step = (phase == len - 4'h1) ? 4'h0 : phase + 4'h1;
  endfunction
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync1 <= '0;
      sync2 <= '0;
      prev  <= '0;
    end else begin
      sync1 <= {in_clk, output_clock_reset, calibration_running, scs_n, sclk, sdata,
                demux_1to2, demux_zero_phase, sdr_mode, output_edge};
      sync2 <= sync1;
      prev  <= sync2;
    end
  end
  assign ic_rise  = sync2[9] && !prev[9];
  assign ic_fall  = !sync2[9] && prev[9];
  assign orst_s   = sync2[8];
  assign cal_s    = sync2[7];
  assign scs_n_s  = sync2[6];
  assign sck_rise = sync2[5] && !prev[5];
  // serial write port: 4-bit address then 16-bit data, taken on sclk rise
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bit_count    <= '0;
      shift        <= '0;
      word_done    <= 1'b0;
      write_strobe <= 1'b0;
    end else begin
      write_strobe <= 1'b0;
      if (scs_n_s) begin
        bit_count <= '0;
        word_done <= 1'b0;
      end else if (sck_rise && !word_done) begin
        shift <= {shift[18:0], sync2[4]};
        if (bit_count == clock_sync_pkg::FRAME_LAST) begin
          word_done    <= 1'b1;
          write_strobe <= 1'b1;
        end else begin
          bit_count <= bit_count + 5'h1;
        end
      end
    end
  end
  assign write_addr = shift[19:16];
  assign write_data = shift[15:0];
  // write-only registers; unused low bits are stored but steer nothing
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      reg_ext    <= clock_sync_pkg::RST_EXT_CONFIG;
      reg_gain   <= clock_sync_pkg::RST_GAIN;
      reg_fine   <= clock_sync_pkg::RST_FINE;
      reg_coarse <= clock_sync_pkg::RST_COARSE;
    end else if (write_strobe) begin
      case (write_addr)
        clock_sync_pkg::ADDR_EXT_CONFIG: reg_ext    <= write_data; // R20
        clock_sync_pkg::ADDR_GAIN:       reg_gain   <= write_data; // R1
        clock_sync_pkg::ADDR_FINE:       reg_fine   <= write_data; // R5
        clock_sync_pkg::ADDR_COARSE:     reg_coarse <= write_data; // R9
        default:                         ;
      endcase
    end
  end
  // gain reaches the analog side directly, no calibration request raised
  assign gain_code                = reg_gain[clock_sync_pkg::GAIN_MSB:clock_sync_pkg::GAIN_LSB]; // R3
  assign fine_phase               = reg_fine[clock_sync_pkg::FINE_MSB:clock_sync_pkg::FINE_LSB]; // R5
  assign coarse_phase             = reg_coarse[clock_sync_pkg::COARSE_MSB:clock_sync_pkg::COARSE_LSB]; // R9
  assign intermediate_phase_field = reg_coarse[clock_sync_pkg::INTER_MSB:clock_sync_pkg::INTER_LSB]; // R7
  assign sample_clock_invert      = reg_coarse[clock_sync_pkg::INVERT_BIT]; // R6
  assign test_pattern_enable      = reg_ext[clock_sync_pkg::PATTERN_BIT]; // R20
  assign keep_clock_running       = reg_ext[clock_sync_pkg::KEEP_CLOCK_BIT];
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      range_mv        <= 10'(clock_sync_pkg::RANGE_MIN_MV + clock_sync_pkg::RANGE_SPAN_MV / 2);
      sample_delay_ps <= '0;
    end else begin
      range_mv <= 10'(clock_sync_pkg::RANGE_MIN_MV
                  + (32'(gain_code) * clock_sync_pkg::RANGE_SPAN_MV)
                  / clock_sync_pkg::GAIN_FULL_CODE); // R1
      // summed steps reach at most 2092 ps; the clamp at 2100 ps never engages
      if (32'(coarse_phase) * clock_sync_pkg::COARSE_STEP_PS
          + 32'(intermediate_phase_field) * clock_sync_pkg::INTER_STEP_PS
          > clock_sync_pkg::MAX_DELAY_PS) begin
        sample_delay_ps <= 12'(clock_sync_pkg::MAX_DELAY_PS); // R8
      end else begin
        sample_delay_ps <= 12'(32'(coarse_phase) * clock_sync_pkg::COARSE_STEP_PS
                           + 32'(intermediate_phase_field) * clock_sync_pkg::INTER_STEP_PS); // R7
      end
    end
  end
  // output clock: reset, synchronised release and restart
  function automatic logic sdr_mode_level(input logic sdr, input logic edge_sel);
    sdr_mode_level = sdr ? edge_sel : !edge_sel;
  endfunction
  assign hold_level = sdr_mode_level(sync2[1], sync2[0]);

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state         <= clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN;
      restart_count <= '0;
      tod_count     <= '0;
    end else if (orst_s) begin
      state <= clock_sync_pkg::OUTPUT_DATA_CLOCK_HELD; // R12
    end else begin
      case (state)
        clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN: state <= clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN;
        clock_sync_pkg::OUTPUT_DATA_CLOCK_HELD: state <= clock_sync_pkg::OUTPUT_DATA_CLOCK_FALL;
        clock_sync_pkg::OUTPUT_DATA_CLOCK_FALL: begin
          if (ic_fall) begin // R14
            state         <= clock_sync_pkg::OUTPUT_DATA_CLOCK_COUNT;
            restart_count <= (sync2[3] && sync2[2]) ? clock_sync_pkg::RESTART_DEMUX0
                                                    : clock_sync_pkg::RESTART_OTHER; // R15
          end
        end
        clock_sync_pkg::OUTPUT_DATA_CLOCK_COUNT: begin
          if (ic_rise) begin
            if (restart_count == 3'h1) begin
              state     <= clock_sync_pkg::OUTPUT_DATA_CLOCK_TOD;
              tod_count <= clock_sync_pkg::TOD_CYC; // R15
            end
            restart_count <= restart_count - 3'h1;
          end
        end
        clock_sync_pkg::OUTPUT_DATA_CLOCK_TOD: begin
          if (tod_count == 4'h1) begin
            state <= clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN;
          end
          tod_count <= tod_count - 4'h1;
        end
        default: state <= clock_sync_pkg::OUTPUT_DATA_CLOCK_HELD;
      endcase
    end
  end
  assign clock_stopped = (cal_s && !keep_clock_running) || (!scs_n_s && !word_done); // R17
  assign toggle = (state == clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN) && !orst_s && ic_fall
                  && !clock_stopped && (!sync2[3] || div_phase);
  // sdr moves a word once per output period, otherwise once per edge
  assign word_evt = toggle && (!sync2[1] || (output_data_clock == hold_level));
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      output_data_clock <= 1'b0;
      div_phase         <= 1'b0;
      data_clock_valid  <= 1'b0;
    end else begin
      if (orst_s || state != clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN) begin
        // forced at once: a high phase in flight may be cut short
        output_data_clock <= hold_level; // R13
        div_phase         <= 1'b0;
      end else if (ic_fall && !clock_stopped) begin
        div_phase <= !div_phase;
        if (toggle) begin
          output_data_clock <= !output_data_clock;
        end
      end
      data_clock_valid <= (state == clock_sync_pkg::OUTPUT_DATA_CLOCK_RUN) && !orst_s
                          && !clock_stopped; // R10
    end
  end
  // test pattern generator
  assign pat_len = sync2[3] ? clock_sync_pkg::PAT_LEN_DEMUX : clock_sync_pkg::PAT_LEN_SINGLE;
  assign i_flip  = pattern_flip(i_phase, sync2[3]); // R19
  assign q_flip  = pattern_flip(q_phase, sync2[3]); // R19
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      i_phase      <= '0;
      q_phase      <= '0;
      q_lag        <= 1'b0;
      pattern_prev <= 1'b0;
    end else begin
      pattern_prev <= test_pattern_enable;
      if (orst_s || !test_pattern_enable) begin
        i_phase <= '0; // R21
        q_phase <= '0;
        q_lag   <= 1'b0;
      end else begin
        if (!pattern_prev) begin
          q_lag <= 1'b1; // R22
        end
        if (word_evt && buf_in_ready) begin
          i_phase <= phase_step(i_phase, pat_len);
          if (q_lag) begin
            q_lag <= 1'b0; // R22
          end else begin
            q_phase <= phase_step(q_phase, pat_len);
          end
        end
      end
    end
  end

  // word layout: {range, qd, id, q, i}
  always_comb begin
    if (test_pattern_enable) begin
      next_word = {i_flip,
                   clock_sync_pkg::PAT_QD ^ {8{q_flip}},
                   clock_sync_pkg::PAT_ID ^ {8{i_flip}},
                   (sync2[3] ? clock_sync_pkg::PAT_Q_DEMUX
                             : clock_sync_pkg::PAT_Q_SINGLE) ^ {8{q_flip}},
                   (sync2[3] ? clock_sync_pkg::PAT_I_DEMUX
                             : clock_sync_pkg::PAT_I_SINGLE) ^ {8{i_flip}}}; // R18
    end else begin
      next_word = {conv_or, conv_qd, conv_id, conv_q, conv_i};
    end
  end
  assign buf_in_valid = word_evt && (test_pattern_enable || conv_valid); // R18
  assign conv_ready   = word_evt && !test_pattern_enable && buf_in_ready;
  word_buffer #(
    .WIDTH (clock_sync_pkg::WORD_W),
    .DEPTH (2)
  ) u_buffer (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (buf_in_valid),
    .in_ready  (buf_in_ready),
    .in_data   (next_word),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (buf_out_data)
  );

  assign out_i  = buf_out_data[7:0];
  assign out_q  = buf_out_data[15:8];
  assign out_id = buf_out_data[23:16];
  assign out_qd = buf_out_data[31:24];
  assign out_or = buf_out_data[32];
endmodule // sample_clock_sync
`default_nettype wire

// ===== test/clock_sync_monitor.sv
// port checker for the sample clock sync block
`timescale 1ns/1ns
`default_nettype none
module clock_sync_monitor (
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        output_clock_reset,
  input wire logic        calibration_running,
  input wire logic        sdr_mode,
  input wire logic        output_edge,
  input wire logic        scs_n,
  input wire logic        conv_valid,
  input wire logic        conv_ready,
  input wire logic        test_pattern_enable,
  input wire logic        out_valid,
  input wire logic        out_ready,
  input wire logic [7:0]  out_i,
  input wire logic        output_data_clock,
  input wire logic        data_clock_valid,
  input wire logic [8:0]  gain_code,
  input wire logic [9:0]  range_mv,
  input wire logic [4:0]  coarse_phase,
  input wire logic [2:0]  intermediate_phase_field,
  input wire logic [11:0] sample_delay_ps,
  input wire logic        keep_clock_running
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  int dly;
  assign dly = 32'(coarse_phase) * clock_sync_pkg::COARSE_STEP_PS
             + 32'(intermediate_phase_field) * 32'hb;
  sequence s_held; output_clock_reset [*4]; endsequence
  sequence s_cal; (calibration_running && !keep_clock_running) [*4]; endsequence
  property p_held; s_held |-> output_data_clock == (sdr_mode ? output_edge : !output_edge);
  endproperty
  a_held: assert property (p_held) else $error("clock not at held level");
  property p_range; range_mv == 10'(32'h230 + 32'($past(gain_code)) * 32'h118 / 32'h1ff);
  endproperty
  a_range: assert property (p_range) else $error("range off gain code");
  property p_delay;
    sample_delay_ps == ($past(dly) > 32'h834 ? 12'h834 : 12'($past(dly)));
  endproperty
  a_delay: assert property (p_delay) else $error("delay off phase fields");
  property p_quiet; $fell(output_clock_reset) |-> $stable(output_data_clock) [*8]; endproperty
  a_quiet: assert property (p_quiet) else $error("clock restarted early");
  property p_bound; $fell(output_clock_reset) |-> ##[16:300] data_clock_valid; endproperty
  a_bound: assert property (p_bound) else $error("clock never restarted");
  property p_cal; s_cal |=> $stable(output_data_clock) && !data_clock_valid; endproperty
  a_cal: assert property (p_cal) else $error("clock ran in calibration");
  property p_frame; $fell(scs_n) |-> ##4 !data_clock_valid [*8]; endproperty
  a_frame: assert property (p_frame) else $error("clock valid in frame");
  property p_buf; out_valid && !out_ready |=> out_valid && $stable(out_i); endproperty
  a_buf: assert property (p_buf) else $error("stalled word lost");
  property p_take; conv_ready && conv_valid |-> !test_pattern_enable ##1 out_valid; endproperty
  a_take: assert property (p_take) else $error("taken word not buffered");
endmodule // clock_sync_monitor
`default_nettype wire

// ===== test/cfg_host.sv
// host model writing register frames on the serial port
`timescale 1ns/1ns
`default_nettype none
module cfg_host #(
  parameter int HALF = 4
) (
  input  wire logic        clk,
  input  wire logic        start,
  input  wire logic [19:0] frame,
  output logic             scs_n,
  output logic             sclk,
  output logic             sdata,
  output logic             busy
);
  int i;
  initial begin
    {scs_n, sclk, sdata, busy} = 4'ha;
    forever begin
      @(posedge clk);
      // one frame per request, sent for whatever address and data the bench gives
      if (start) begin
        busy = 1;
        #1 scs_n = 0;
        for (i = 19; i >= 0; i--) begin
          sdata = frame[i];
          repeat (HALF) @(posedge clk);
          #1 sclk = 1;
          repeat (HALF) @(posedge clk);
          #1 sclk = 0;
        end
        repeat (HALF) @(posedge clk);
        #1 scs_n = 1;
        // released line shows no stale bit
        sdata = ~sdata;
        repeat (HALF) @(posedge clk);
        #1 busy = 0;
      end
    end
  end
endmodule // cfg_host
`default_nettype wire

// ===== test/sample_clock_phase_and_output_clock_sync_tb.sv
// self-checking bench for the sample clock sync block
`timescale 1ns/1ns
`default_nettype none
module sample_clock_phase_and_output_clock_sync_tb;
  logic        clk, rst_n, in_clk, output_clock_reset, calibration_running, demux_1to2;
  logic        demux_zero_phase, sdr_mode, output_edge, scs_n, sclk, sdata, conv_or;
  logic        conv_valid, conv_ready, out_or, out_valid, out_ready, output_data_clock;
  logic        data_clock_valid, sample_clock_invert, test_pattern_enable, start, busy;
  logic        keep_clock_running;
  logic [7:0]  conv_i, conv_q, conv_id, conv_qd, out_i, out_q, out_id, out_qd, fine_phase;
  logic [8:0]  gain_code;
  logic [9:0]  range_mv;
  logic [4:0]  coarse_phase;
  logic [2:0]  intermediate_phase_field;
  logic [11:0] sample_delay_ps;
  logic [19:0] frame;
  int          miscompares, cmp_count, cycles, k;
  sample_clock_sync i_dut (.*);
  // minimum legal serial phase of 3 clk
  cfg_host #(.HALF(3)) i_host (.*);
  initial begin clk = 0; forever #5 clk = ~clk; end
  initial begin in_clk = 0; #3; forever #40 in_clk = ~in_clk; end
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("FAIL %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask
  task automatic tally_and_finish;
    if (miscompares == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [3:0] ad, input logic [15:0] d);
    int n;
    frame = {ad, d};
    start = 1;
    @(posedge clk);
    #1 start = 0;
    for (n = 0; n < 400 && busy !== 0; n++) @(posedge clk);
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic t_regs;
    chk("rst", 36'h1002bc, 36'({gain_code, 2'b0, range_mv}));
    chk("rst", 36'h0, 36'({sample_clock_invert, coarse_phase, intermediate_phase_field,
        fine_phase, test_pattern_enable, sample_delay_ps}));
    wr(4'hb, 16'hffff);
    chk("gain", 36'h1ff348, 36'({gain_code, 2'b0, range_mv}));
    wr(4'hb, 16'h007f);
    chk("range", 36'h230, 36'(range_mv));
    wr(4'hb, 16'he07f);
    chk("range", 36'h325, 36'(range_mv));
    wr(4'he, 16'hffff);
    chk("fine", 36'hff, 36'(fine_phase));
    wr(4'hf, 16'hffff);
    chk("crs", 36'h1ff82c, 36'({sample_clock_invert, coarse_phase,
        intermediate_phase_field, sample_delay_ps}));
    wr(4'hf, 16'h04ff);
    wr(4'hc, 16'h0000);
    chk("crs", 36'h00904c, 36'({sample_clock_invert, coarse_phase,
        intermediate_phase_field, sample_delay_ps}));
  endtask
  task automatic t_buffer;
    out_ready = 1;
    {conv_qd, conv_id, conv_q, conv_i} = {4{8'h5a}};
    repeat (40) @(posedge clk);
    #1 out_ready = 0;
    for (k = 0; k < 100 && out_valid !== 1; k++) @(posedge clk);
    #1 {conv_qd, conv_id, conv_q, conv_i} = {4{8'ha5}};
    repeat (64) @(posedge clk);
    #1 chk("held", 36'h5a5a5a5a, 36'({out_qd, out_id, out_q, out_i}));
    out_ready = 1;
    @(posedge clk);
    #1 out_ready = 0;
    chk("next", 36'ha5a5a5a5, 36'({out_qd, out_id, out_q, out_i}));
  endtask
  task automatic t_pattern;
    out_ready = 1;
    output_clock_reset = 1;
    repeat (8) @(posedge clk);
    #1 chk("hold", 36'h1, 36'(output_data_clock));
    wr(4'h9, 16'h83ff);
    chk("tpe", 36'h1, 36'({keep_clock_running, test_pattern_enable}));
    repeat (20) @(posedge clk);
    #1 output_clock_reset = 0;
    for (int s = 0; s < 6; s++) begin
      for (k = 0; k < 300 && out_valid !== 1; k++) begin
        @(posedge clk);
        #1;
      end
      chk("pat", (s % 5) % 2 ? 36'h1fefdfcfb : 36'h001020304,
          {3'h0, out_or, out_qd, out_id, out_q, out_i});
      @(posedge clk);
      #1;
    end
  endtask
  task automatic t_cal;
    chk("dcv", 36'h1, 36'(data_clock_valid));
    calibration_running = 1;
    repeat (12) @(posedge clk);
    #1 chk("cal", 36'h0, 36'(data_clock_valid));
    calibration_running = 0;
  endtask
  // pattern switched on while the clock runs: q side trails i by one word
  task automatic t_lag;
    logic ip;
    ip = 1'b0;
    wr(4'h9, 16'h03ff);
    wr(4'h9, 16'h83ff);
    for (int s = 0; s < 6; s++) begin
      for (k = 0; k < 300 && out_valid !== 1; k++) begin
        @(posedge clk);
        #1;
      end
      if (s > 0) chk("lag", 36'(ip), 36'(out_q == 8'hfc));
      ip = (out_i == 8'hfb);
      @(posedge clk);
      #1;
    end
  endtask
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  initial begin
    {rst_n, output_clock_reset, calibration_running, demux_zero_phase, conv_or} = 5'h0;
    {demux_1to2, sdr_mode, output_edge, conv_valid, out_ready, start} = 6'h3c;
    {conv_qd, conv_id, conv_q, conv_i, frame} = 52'h0;
    {miscompares, cmp_count, cycles} = 96'h0;
    repeat (8) @(posedge clk);
    #1 rst_n = 1;
    repeat (4) @(posedge clk);
    #1 t_regs();
    t_buffer();
    t_pattern();
    t_cal();
    t_lag();
    tally_and_finish();
  end
endmodule // sample_clock_phase_and_output_clock_sync_tb
bind sample_clock_sync clock_sync_monitor i_mon (.*);
`default_nettype wire
